// ### verilog/ctm_pkg.sv
/*
  shared constants for the can transceiver mode logic: clock rate, time base,
  dominant timeout, undervoltage recovery, wake-up filter and reset values.
  assumes a single 100 MHz system clock for both ends.
*/
package ctm_pkg;

  // ****************************************************************
  // clock
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 10;

  // ****************************************************************
  // bit rate
  // ****************************************************************
  localparam int MAX_BIT_RATE_BPS = 1000000;
  localparam int BIT_TIME_NS      = 1000000000 / MAX_BIT_RATE_BPS;
  localparam int BIT_CYC          = BIT_TIME_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // wake-up filter time base
  // ****************************************************************
  localparam int TIME_BASE_NS     = 50;
  localparam int TIME_BASE_CYC    = (TIME_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_FILT_LEN    = 10;

  // ****************************************************************
  // protection timing
  // ****************************************************************
  localparam int DOM_TIMEOUT_US   = 1000;
  localparam int DOM_TIMEOUT_CYC  = (DOM_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int UV_RECOVER_US    = 300;
  localparam int UV_RECOVER_CYC   = (UV_RECOVER_US * 1000) / CLK_PERIOD_NS;

  // ****************************************************************
  // synchroniser reset value: {txd, standby select, bus dominant, main uv, logic uv}
  // ****************************************************************
  localparam logic [4:0] SYNC_RST = 5'h1b;
  localparam int         SYNC_TXD = 4;
  localparam int         SYNC_STB = 3;
  localparam int         SYNC_BUS = 2;
  localparam int         SYNC_MUV = 1;
  localparam int         SYNC_LUV = 0;

  typedef enum logic {
    MODE_NORMAL,
    MODE_STANDBY
  } ctm_mode_t;

  typedef enum logic [1:0] {
    CTL_ACTIVE,
    CTL_SLEEP,
    CTL_POWER_UP
  } ctm_ctl_state_t;

endpackage

// ### verilog/ctm_link_if.sv
/*
  logic-side pins between protocol controller and transceiver: transmit data,
  standby select and receive data, each with an output enable.
  assumes open transmit and standby inputs are pulled high and an undriven
  receive line reads high at the controller.
*/
`timescale 1ns/1ps
interface ctm_link_if;
  logic txdOut;
  logic txdOe;
  logic stbyOut;
  logic stbyOe;
  logic rxdOut;
  logic rxdOe;
  logic txdLevel;
  logic stbyLevel;
  logic rxdLevel;

  // pin resolution, open inputs pulled high
  assign txdLevel  = txdOe  ? txdOut  : 1'b1;
  assign stbyLevel = stbyOe ? stbyOut : 1'b1;
  assign rxdLevel  = rxdOe  ? rxdOut  : 1'b1;

  modport dev (
    input  txdLevel,
    input  stbyLevel,
    output rxdOut,
    output rxdOe
  );

  modport ctl (
    output txdOut,
    output txdOe,
    output stbyOut,
    output stbyOe,
    input  rxdLevel
  );
endinterface

// ### verilog/ctm_device.sv
/*
  transceiver end: mode selection, transmit to bus, bus to receive, standby
  wake-up filter, stuck-dominant lockout, dominant timeout, forced standby.
  assumes the bus side is abstracted to a sensed dominant level and drive and
  bias controls; all pin inputs are asynchronous and synchronised here.
*/
// Contract
// - standby select low: normal, driver and receiver on
// - standby select high: standby, only wake receiver
// - normal: transmit low drives dominant, else recessive
// - normal: receive output follows bus level
// - standby: receive low after filtered dominant only
// - controller watches receive output, wakes device
// - controller restores main supply before normal
// - stuck dominant at standby entry locks out wake
// - normal recessive biases mid-supply, dominant drives apart
// - standby weakly biases bus lines to ground
// - paths support one megabit per second
// - dominant timeout disables driver until transmit recessive
// - open standby select defaults to standby
// - supply undervoltage forces standby
`timescale 1ns/1ps
module ctm_device #(
  parameter int DOM_TIMEOUT_CYC = ctm_pkg::DOM_TIMEOUT_CYC,
  parameter int UV_RECOVER_CYC  = ctm_pkg::UV_RECOVER_CYC,
  parameter int WAKE_FILT_LEN   = ctm_pkg::WAKE_FILT_LEN,
  parameter bit LEVEL_ADAPT     = 1'b1
) (
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  ctm_link_if.dev     link,
  input  wire logic   busDomIn,
  input  wire logic   mainUv,
  input  wire logic   logicUv,
  output logic        busDrvDom,
  output logic        busBiasMid,
  output logic        busBiasGnd,
  output logic        wakeLockout,
  output logic        domTimeout
);

  localparam int DOM_W  = $clog2(DOM_TIMEOUT_CYC + 1);
  localparam int UV_W   = $clog2(UV_RECOVER_CYC + 1);
  localparam int WAKE_W = $clog2(WAKE_FILT_LEN + 1);
  localparam int TB_W   = $clog2(ctm_pkg::TIME_BASE_CYC + 1);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [4:0] syncA_q;
  logic [4:0] syncB_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      syncA_q <= ctm_pkg::SYNC_RST;
      syncB_q <= ctm_pkg::SYNC_RST;
    end else begin
      syncA_q <= {link.txdLevel, link.stbyLevel, busDomIn, mainUv, logicUv};
      syncB_q <= syncA_q;
    end
  end

  logic txdS;
  logic stbyS;
  logic busDomS;
  logic mainUvS;
  logic logicUvS;

  assign txdS     = syncB_q[ctm_pkg::SYNC_TXD];
  assign stbyS    = syncB_q[ctm_pkg::SYNC_STB];
  assign busDomS  = syncB_q[ctm_pkg::SYNC_BUS];
  assign mainUvS  = syncB_q[ctm_pkg::SYNC_MUV];
  assign logicUvS = syncB_q[ctm_pkg::SYNC_LUV];

  // ****************************************************************
  // undervoltage forced standby with recovery hold
  // ****************************************************************
  logic [UV_W-1:0] uvCnt_q;
  logic            forcedStby;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      uvCnt_q <= '0;
    end else if (mainUvS || logicUvS) begin
      uvCnt_q <= UV_W'(UV_RECOVER_CYC);
    end else if (uvCnt_q != '0) begin
      uvCnt_q <= uvCnt_q - 1'b1;
    end
  end

  assign forcedStby = mainUvS || logicUvS || (uvCnt_q != '0);

  // ****************************************************************
  // mode selection
  // ****************************************************************
  ctm_pkg::ctm_mode_t mode_q;
  ctm_pkg::ctm_mode_t mode_d;

  always_comb begin
    if (stbyS || forcedStby) begin
      mode_d = ctm_pkg::MODE_STANDBY;
    end else begin
      mode_d = ctm_pkg::MODE_NORMAL;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q <= ctm_pkg::MODE_STANDBY;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ****************************************************************
  // dominant timeout
  // ****************************************************************
  logic [DOM_W-1:0] domCnt_q;
  logic             domTimeout_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      domCnt_q <= '0;
    end else if (mode_q != ctm_pkg::MODE_NORMAL || txdS) begin
      domCnt_q <= '0;
    end else if (domCnt_q != DOM_W'(DOM_TIMEOUT_CYC)) begin
      domCnt_q <= domCnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      domTimeout_q <= 1'b0;
    end else if (mode_q != ctm_pkg::MODE_NORMAL || txdS) begin
      domTimeout_q <= 1'b0;
    end else if (domCnt_q == DOM_W'(DOM_TIMEOUT_CYC - 1)) begin
      domTimeout_q <= 1'b1;
    end
  end

  // ****************************************************************
  // wake-up filter time base
  // ****************************************************************
  logic [TB_W-1:0] tbCnt_q;
  logic            tick;

  assign tick = (tbCnt_q == TB_W'(ctm_pkg::TIME_BASE_CYC - 1));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tbCnt_q <= '0;
    end else if (tick) begin
      tbCnt_q <= '0;
    end else begin
      tbCnt_q <= tbCnt_q + 1'b1;
    end
  end

  // ****************************************************************
  // wake-up filter
  // ****************************************************************
  logic [WAKE_W-1:0] wakeCnt_q;
  logic              wakeReq;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wakeCnt_q <= '0;
    end else if (mode_q != ctm_pkg::MODE_STANDBY || !busDomS || logicUvS) begin
      wakeCnt_q <= '0;
    end else if (tick && wakeCnt_q != WAKE_W'(WAKE_FILT_LEN)) begin
      wakeCnt_q <= wakeCnt_q + 1'b1;
    end
  end

  // ****************************************************************
  // stuck-dominant lockout
  // ****************************************************************
  logic lockout_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lockout_q <= 1'b0;
    end else if (!LEVEL_ADAPT || !busDomS) begin
      lockout_q <= 1'b0;
    end else if (mode_q == ctm_pkg::MODE_NORMAL && mode_d == ctm_pkg::MODE_STANDBY) begin
      lockout_q <= 1'b1;
    end
  end

  assign wakeReq = (wakeCnt_q == WAKE_W'(WAKE_FILT_LEN)) && !lockout_q;

  // ****************************************************************
  // receive output
  // ****************************************************************
  logic rxd_q;
  logic rxdOe_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxd_q   <= 1'b1;
      rxdOe_q <= 1'b0;
    end else begin
      rxdOe_q <= !logicUvS;
      if (mode_q == ctm_pkg::MODE_NORMAL) begin
        rxd_q <= !busDomS;
      end else begin
        rxd_q <= !wakeReq;
      end
    end
  end

  assign link.rxdOut = rxd_q;
  assign link.rxdOe  = rxdOe_q;

  // ****************************************************************
  // bus drive and bias
  // ****************************************************************
  logic busDrvDom_q;
  logic busBiasMid_q;
  logic busBiasGnd_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busDrvDom_q  <= 1'b0;
      busBiasMid_q <= 1'b0;
      busBiasGnd_q <= 1'b1;
    end else begin
      busDrvDom_q  <= (mode_q == ctm_pkg::MODE_NORMAL) && !txdS && !domTimeout_q;
      busBiasMid_q <= (mode_q == ctm_pkg::MODE_NORMAL);
      busBiasGnd_q <= (mode_q == ctm_pkg::MODE_STANDBY);
    end
  end

  assign busDrvDom   = busDrvDom_q;
  assign busBiasMid  = busBiasMid_q;
  assign busBiasGnd  = busBiasGnd_q;
  assign wakeLockout = lockout_q;
  assign domTimeout  = domTimeout_q;

endmodule

// ### verilog/ctm_controller.sv
/*
  protocol controller end: drives transmit data and standby select, watches
  the receive output for wake-up requests and sequences the main supply.
  assumes an external supply switch with a good indication on a pin.
*/
`timescale 1ns/1ps
module ctm_controller #(
  parameter bit SUPPLY_OFF_IN_SLEEP = 1'b1
) (
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  ctm_link_if.ctl     link,
  input  wire logic   txData,
  input  wire logic   sleepReq,
  input  wire logic   mainSupplyGood,
  output logic        rxData,
  output logic        wakeEvent,
  output logic        mainSupplyEn,
  output logic        inStandby
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [1:0] syncA_q;
  logic [1:0] syncB_q;
  logic       rxdPrev_q;
  logic       rxdS;
  logic       goodS;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      syncA_q   <= 2'h2;
      syncB_q   <= 2'h2;
      rxdPrev_q <= 1'b1;
    end else begin
      syncA_q   <= {link.rxdLevel, mainSupplyGood};
      syncB_q   <= syncA_q;
      rxdPrev_q <= syncB_q[1];
    end
  end

  assign rxdS  = syncB_q[1];
  assign goodS = syncB_q[0];

  // ****************************************************************
  // sequencer
  // ****************************************************************
  ctm_pkg::ctm_ctl_state_t state_q;
  logic txd_q;
  logic txdOe_q;
  logic stby_q;
  logic stbyOe_q;
  logic rxData_q;
  logic wake_q;
  logic supplyEn_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q    <= ctm_pkg::CTL_POWER_UP;
      txd_q      <= 1'b1;
      txdOe_q    <= 1'b0;
      stby_q     <= 1'b1;
      stbyOe_q   <= 1'b0;
      rxData_q   <= 1'b1;
      wake_q     <= 1'b0;
      supplyEn_q <= 1'b1;
    end else begin
      wake_q <= 1'b0;
      unique case (state_q)
        ctm_pkg::CTL_ACTIVE: begin
          txd_q    <= txData;
          rxData_q <= rxdS;
          if (sleepReq) begin
            state_q    <= ctm_pkg::CTL_SLEEP;
            txd_q      <= 1'b1;
            stby_q     <= 1'b1;
            supplyEn_q <= !SUPPLY_OFF_IN_SLEEP;
          end
        end
        ctm_pkg::CTL_SLEEP: begin
          rxData_q <= 1'b1;
          if (rxdPrev_q && !rxdS) begin
            wake_q     <= 1'b1;
            state_q    <= ctm_pkg::CTL_POWER_UP;
            supplyEn_q <= 1'b1;
          end else if (!sleepReq) begin
            state_q    <= ctm_pkg::CTL_POWER_UP;
            supplyEn_q <= 1'b1;
          end
        end
        ctm_pkg::CTL_POWER_UP: begin
          rxData_q   <= 1'b1;
          supplyEn_q <= 1'b1;
          if (goodS && supplyEn_q && !sleepReq) begin
            state_q  <= ctm_pkg::CTL_ACTIVE;
            txdOe_q  <= 1'b1;
            txd_q    <= 1'b1;
            stbyOe_q <= 1'b1;
            stby_q   <= 1'b0;
          end
        end
      endcase
    end
  end

  assign link.txdOut  = txd_q;
  assign link.txdOe   = txdOe_q;
  assign link.stbyOut = stby_q;
  assign link.stbyOe  = stbyOe_q;
  assign rxData       = rxData_q;
  assign wakeEvent    = wake_q;
  assign mainSupplyEn = supplyEn_q;
  assign inStandby    = stby_q;

endmodule

// ### verification/ctm_link_sva.sv
/*
  checker for the transceiver link and the device's bus-side outputs.
  assumes it is instantiated beside the link interface, fed by name.
*/
`timescale 1ns/1ps
module ctm_link_sva #(
  parameter int DOM_TIMEOUT_CYC = ctm_pkg::DOM_TIMEOUT_CYC,
  parameter int WAKE_FILT_LEN   = ctm_pkg::WAKE_FILT_LEN
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic txdLevel,
  input wire logic stbyLevel,
  input wire logic rxdOut,
  input wire logic rxdOe,
  input wire logic busDomIn,
  input wire logic mainUv,
  input wire logic logicUv,
  input wire logic busDrvDom,
  input wire logic busBiasMid,
  input wire logic busBiasGnd,
  input wire logic wakeLockout,
  input wire logic domTimeout
);
  // ****************************************************************
  // helper counters
  // ****************************************************************
  // shortest dominant run that can raise a wake request
  localparam int FILT_MIN = (WAKE_FILT_LEN - 1) * ctm_pkg::TIME_BASE_CYC + 4;
  logic [7:0]  domCnt_q;
  logic [31:0] txLowCnt_q;
  logic        normOk;
  assign normOk = busBiasMid && !stbyLevel && !mainUv && !logicUv;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      domCnt_q <= 8'h00;
    end else if (!busDomIn) begin
      domCnt_q <= 8'h00;
    end else if (domCnt_q != 8'hff) begin
      domCnt_q <= domCnt_q + 8'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txLowCnt_q <= 32'h00000000;
    end else if (!normOk || txdLevel) begin
      txLowCnt_q <= 32'h00000000;
    end else if (txLowCnt_q != 32'hffffffff) begin
      txLowCnt_q <= txLowCnt_q + 32'h00000001;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_txdLow;
    (normOk && !txdLevel && !domTimeout) [*5];
  endsequence
  sequence s_wakeFall;
    stbyLevel && $past(stbyLevel, 4) && rxdOe && $fell(rxdOut);
  endsequence
  AST_OPEN_STBY: assert property ($rose(resetn) |-> stbyLevel)
    else $error("open standby select not read high");
  AST_BIAS_EXCL: assert property (busBiasMid != busBiasGnd)
    else $error("bias outputs not exclusive");
  AST_DRV_OFF_STANDBY: assert property (busBiasGnd |-> !busDrvDom)
    else $error("driver on in standby");
  AST_TXD_DOM: assert property (s_txdLow |-> busDrvDom)
    else $error("transmit low not driven dominant");
  AST_TXD_REC: assert property (txdLevel [*5] |-> !busDrvDom)
    else $error("transmit high drove dominant");
  AST_RX_DOM: assert property ((normOk && busDomIn) [*5] |-> !rxdOut)
    else $error("receive not low on dominant bus");
  AST_RX_REC: assert property ((normOk && !busDomIn) [*5] |-> rxdOut)
    else $error("receive not high on recessive bus");
  AST_WAKE_FILT: assert property (s_wakeFall |-> domCnt_q >= FILT_MIN)
    else $error("wake request on short dominant");
  AST_LOCKOUT: assert property (wakeLockout && $past(wakeLockout) |-> rxdOut)
    else $error("wake request during lockout");
  AST_DOM_TIMEOUT: assert property (txLowCnt_q > DOM_TIMEOUT_CYC + 6 |-> domTimeout && !busDrvDom)
    else $error("dominant timeout missing");
  AST_UV_STANDBY: assert property ((mainUv || logicUv) [*6] |-> busBiasGnd && !busDrvDom)
    else $error("undervoltage did not force standby");
  AST_RXD_HIZ: assert property (logicUv [*4] |-> !rxdOe)
    else $error("receive driven during logic undervoltage");
endmodule

// ### verification/can_transceiver_mode_logic_test.sv
/*
  testbench joining controller and device ends over the link interface.
  assumes the bench models the bus as own drive or other nodes' dominant.
*/
`timescale 1ns/1ps
module can_transceiver_mode_logic_test;
  localparam int TO_CYC = 12 * ctm_pkg::BIT_CYC;
  localparam int WF_LEN = 3;
  logic clk_sys  = 1'b0;
  logic resetn   = 1'b0;
  logic extDom   = 1'b0;
  logic mainUv   = 1'b0;
  logic logicUv  = 1'b0;
  logic txData   = 1'b1;
  logic sleepReq = 1'b0;
  logic supGood  = 1'b1;
  int   nWake    = 0;
  logic busDomIn, busDrvDom, busBiasMid, busBiasGnd, wakeLockout, domTimeout;
  logic rxData, wakeEvent, mainSupplyEn, inStandby;
  int   n_errors  = 0;
  int   cmp_count = 0;
  int   cycles    = 0;
  ctm_link_if i_ctm_link_if ();
  assign busDomIn = busDrvDom | extDom;
  always #5 clk_sys = ~clk_sys;
  ctm_device #(.DOM_TIMEOUT_CYC(TO_CYC), .UV_RECOVER_CYC(20), .WAKE_FILT_LEN(WF_LEN), .LEVEL_ADAPT(1'b1)) i_ctm_device (
    .clk_sys(clk_sys), .resetn(resetn), .link(i_ctm_link_if.dev), .busDomIn(busDomIn), .mainUv(mainUv),
    .logicUv(logicUv), .busDrvDom(busDrvDom), .busBiasMid(busBiasMid), .busBiasGnd(busBiasGnd),
    .wakeLockout(wakeLockout), .domTimeout(domTimeout));
  ctm_controller #(.SUPPLY_OFF_IN_SLEEP(1'b1)) i_ctm_controller (
    .clk_sys(clk_sys), .resetn(resetn), .link(i_ctm_link_if.ctl), .txData(txData), .sleepReq(sleepReq),
    .mainSupplyGood(supGood), .rxData(rxData), .wakeEvent(wakeEvent), .mainSupplyEn(mainSupplyEn),
    .inStandby(inStandby));
  ctm_link_sva #(.DOM_TIMEOUT_CYC(TO_CYC), .WAKE_FILT_LEN(WF_LEN)) i_ctm_link_sva (
    .clk_sys(clk_sys), .resetn(resetn), .txdLevel(i_ctm_link_if.txdLevel), .stbyLevel(i_ctm_link_if.stbyLevel),
    .rxdOut(i_ctm_link_if.rxdOut), .rxdOe(i_ctm_link_if.rxdOe), .busDomIn(busDomIn), .mainUv(mainUv),
    .logicUv(logicUv), .busDrvDom(busDrvDom), .busBiasMid(busBiasMid), .busBiasGnd(busBiasGnd),
    .wakeLockout(wakeLockout), .domTimeout(domTimeout));
  // ****************************************************************
  // helpers
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (wakeEvent === 1'b1) begin
      nWake <= nWake + 1;
    end
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t value %b expected %b", $time, got, exp);
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_normal();
    for (int i = 0; i < 4; i++) begin
      txData = i[0];
      cyc(ctm_pkg::BIT_CYC);
      chk(busDrvDom, !i[0]);
      chk(rxData, i[0]);
    end
    extDom = 1'b1;
    cyc(12);
    chk(rxData, 1'b0);
    extDom = 1'b0;
    cyc(12);
  endtask
  task automatic t_timeout();
    txData = 1'b0;
    cyc(TO_CYC + 15);
    chk(domTimeout, 1'b1);
    chk(busDrvDom, 1'b0);
    txData = 1'b1;
    cyc(8);
    chk(domTimeout, 1'b0);
    txData = 1'b0;
    cyc(8);
    chk(busDrvDom, 1'b1);
    txData = 1'b1;
    cyc(12);
  endtask
  task automatic t_wake();
    int w0;
    w0 = nWake;
    sleepReq = 1'b1;
    cyc(10);
    chk(inStandby, 1'b1);
    chk(busBiasGnd, 1'b1);
    chk(mainSupplyEn, 1'b0);
    supGood = 1'b0;
    extDom = 1'b1;
    cyc(8);
    extDom = 1'b0;
    cyc(20);
    chk(nWake != w0, 1'b0);
    extDom = 1'b1;
    cyc(30);
    chk(i_ctm_link_if.rxdLevel, 1'b0);
    chk(nWake == w0 + 1, 1'b1);
    chk(mainSupplyEn, 1'b1);
    extDom = 1'b0;
    sleepReq = 1'b0;
    cyc(20);
    chk(inStandby, 1'b1);
    supGood = 1'b1;
    cyc(40);
    chk(busBiasMid, 1'b1);
  endtask
  task automatic t_lockout();
    int w0;
    extDom = 1'b1;
    cyc(10);
    sleepReq = 1'b1;
    cyc(10);
    chk(wakeLockout, 1'b1);
    w0 = nWake;
    cyc(40);
    chk(nWake != w0, 1'b0);
    extDom = 1'b0;
    cyc(10);
    chk(wakeLockout, 1'b0);
    extDom = 1'b1;
    cyc(30);
    chk(nWake == w0 + 1, 1'b1);
    extDom = 1'b0;
    sleepReq = 1'b0;
    cyc(40);
  endtask
  task automatic t_uv();
    mainUv = 1'b1;
    cyc(10);
    chk(busBiasGnd, 1'b1);
    mainUv = 1'b0;
    logicUv = 1'b1;
    extDom = 1'b1;
    cyc(30);
    chk(i_ctm_link_if.rxdOe, 1'b0);
    logicUv = 1'b0;
    extDom = 1'b0;
    cyc(10);
    chk(busBiasGnd, 1'b1);
    cyc(30);
    chk(busBiasMid, 1'b1);
  endtask
  initial begin
    cyc(6);
    chk(i_ctm_link_if.stbyLevel, 1'b1);
    chk(busBiasGnd, 1'b1);
    resetn = 1'b1;
    cyc(40);
    chk(busBiasMid, 1'b1);
    chk(busBiasGnd, 1'b0);
    t_normal();
    t_timeout();
    t_wake();
    t_lockout();
    t_uv();
    complete_run();
  end
endmodule
